//--- cilc_pkg.sv
// Constants for the chassis identify indicator controller.
// Assumes a 125 MHz system clock.
package cilc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CILC_CLK_HZ        = 125000000;
    localparam int unsigned CILC_BLINK_HZ      = 1;
    localparam int unsigned CILC_HALF_PERIOD_CYC = CILC_CLK_HZ / (2 * CILC_BLINK_HZ);
    localparam int unsigned CILC_CNT_W         = 27;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic CILC_RST_PHASE = 1'b0;
    localparam logic CILC_RST_BTN   = 1'b0;

    // ------------------------------------------------------------
    // Indicator states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CILC_OFF   = 3'h1,
        CILC_SOLID = 3'h2,
        CILC_BLINK = 3'h4
    } cilc_state_t;

    // ------------------------------------------------------------
    // Output and state reset values
    // ------------------------------------------------------------
    localparam cilc_state_t CILC_RST_STATE  = CILC_OFF;
    localparam logic        CILC_RST_LED_N  = 1'b1;
    localparam logic        CILC_RST_ACTIVE = 1'b0;

endpackage

//--- cilc_top.sv
// Chassis identify indicator controller: button and command sources.
// Assumes button and command inputs are synchronous, debounced levels/pulses.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Button press toggles steady on/off; from blinking it goes steady.
// - Chassis and vendor commands also set indicator.
// - Button activation gives steady lit indicator.
// - Command activation blinks at 1 Hz; inactive dark.
// - No lock-out between sources; in one cycle vendor beats chassis beats button.
// - Newest activation replaces all earlier ones.
// - Second press without command turns off.
module cilc_top
    import cilc_pkg::*;
(
    input  wire logic I_SYS_CLK,
    input  wire logic I_RST,
    input  wire logic I_FRONT_PANEL_IDENTIFY_BUTTON,
    input  wire logic I_CHASSIS_IDENTIFY_REQ,
    input  wire logic I_CHASSIS_IDENTIFY_ON,
    input  wire logic I_VENDOR_IDENTIFY_REQ,
    input  wire logic I_VENDOR_IDENTIFY_ON,
    output logic      O_IDENTIFY_INDICATOR_OUT_N,
    output logic      O_IDENTIFY_ACTIVE
);

    // ------------------------------------------------------------
    // Internal signals
    // ------------------------------------------------------------
    logic                  btn_reg;
    logic                  btn_next;
    logic                  press;
    logic                  chs_hit;
    logic                  vnd_hit;
    cilc_state_t           chs_target;
    cilc_state_t           vnd_target;
    cilc_state_t           state_reg;
    cilc_state_t           state_next;
    logic [CILC_CNT_W-1:0] cnt_reg;
    logic [CILC_CNT_W-1:0] cnt_next;
    logic                  wrap;
    logic                  phase_reg;
    logic                  phase_next;
    logic                  led_n_next;
    logic                  active_next;

    // ------------------------------------------------------------
    // Command decoding
    // ------------------------------------------------------------
    // Maps the qualifier of a request to the state it asks for.
    function automatic cilc_state_t cmd_target
    (
        input logic on_flag
    );
        cilc_state_t target;
        begin
            target = CILC_OFF;
            if (on_flag)
                target = CILC_BLINK;
            return target;
        end
    endfunction

    // ------------------------------------------------------------
    // Button edge detection
    // ------------------------------------------------------------
    // The previous level is kept so a held button counts once.
    assign btn_next = I_FRONT_PANEL_IDENTIFY_BUTTON;

    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            btn_reg <= CILC_RST_BTN;
        end
        else
        begin
            btn_reg <= btn_next;
        end
    end

    assign press = btn_next & ~btn_reg;

    // ------------------------------------------------------------
    // Command sources
    // ------------------------------------------------------------
    assign chs_hit    = I_CHASSIS_IDENTIFY_REQ;
    assign vnd_hit    = I_VENDOR_IDENTIFY_REQ;
    assign chs_target = cmd_target(I_CHASSIS_IDENTIFY_ON);
    assign vnd_target = cmd_target(I_VENDOR_IDENTIFY_ON);

    // ------------------------------------------------------------
    // Source arbitration
    // ------------------------------------------------------------
    // A command in the same cycle as a press is taken as the later one.
    always_comb
    begin
        state_next = state_reg;
        if (press)
        begin
            if (state_reg == CILC_SOLID)
            begin
                state_next = CILC_OFF;
            end
            else
            begin
                state_next = CILC_SOLID;
            end
        end
        if (chs_hit)
        begin
            state_next = chs_target;
        end
        if (vnd_hit)
        begin
            state_next = vnd_target;
        end
    end

    // ------------------------------------------------------------
    // Indicator state
    // ------------------------------------------------------------
    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            state_reg <= CILC_RST_STATE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Blink prescaler
    // ------------------------------------------------------------
    // The count restarts whenever blinking stops, so each blink starts lit.
    assign wrap = (cnt_reg == CILC_CNT_W'(CILC_HALF_PERIOD_CYC - 1));

    always_comb
    begin
        cnt_next = cnt_reg + CILC_CNT_W'(1);
        if (state_reg != CILC_BLINK || wrap)
        begin
            cnt_next = '0;
        end
    end

    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            cnt_reg <= '0;
        end
        else
        begin
            cnt_reg <= cnt_next;
        end
    end

    // ------------------------------------------------------------
    // Blink phase
    // ------------------------------------------------------------
    always_comb
    begin
        phase_next = phase_reg;
        if (state_reg != CILC_BLINK)
        begin
            phase_next = CILC_RST_PHASE;
        end
        else if (wrap)
        begin
            phase_next = ~phase_reg;
        end
    end

    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            phase_reg <= CILC_RST_PHASE;
        end
        else
        begin
            phase_reg <= phase_next;
        end
    end

    // ------------------------------------------------------------
    // Indicator drive
    // ------------------------------------------------------------
    always_comb
    begin
        led_n_next = CILC_RST_LED_N;
        unique case (state_reg)
            CILC_SOLID: led_n_next = 1'b0;
            CILC_BLINK: led_n_next = phase_reg;
            CILC_OFF:   led_n_next = 1'b1;
            default:    led_n_next = 1'b1;
        endcase
    end

    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            O_IDENTIFY_INDICATOR_OUT_N <= CILC_RST_LED_N;
        end
        else
        begin
            O_IDENTIFY_INDICATOR_OUT_N <= led_n_next;
        end
    end

    // ------------------------------------------------------------
    // Activity flag
    // ------------------------------------------------------------
    assign active_next = (state_reg != CILC_OFF);

    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            O_IDENTIFY_ACTIVE <= CILC_RST_ACTIVE;
        end
        else
        begin
            O_IDENTIFY_ACTIVE <= active_next;
        end
    end

endmodule

`default_nettype wire

//--- cilc_peer.sv
// Model of the front-panel button and the management command path.
// Assumes callers start each task just after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module cilc_peer (
    input  wire logic I_SYS_CLK,
    output var  logic I_FRONT_PANEL_IDENTIFY_BUTTON = 1'b0,
    output var  logic I_CHASSIS_IDENTIFY_REQ = 1'b0,
    output var  logic I_CHASSIS_IDENTIFY_ON = 1'b0,
    output var  logic I_VENDOR_IDENTIFY_REQ = 1'b0,
    output var  logic I_VENDOR_IDENTIFY_ON = 1'b0
);
    // Holds the button two cycles so a held level is seen once.
    task automatic press();
        I_FRONT_PANEL_IDENTIFY_BUTTON <= 1'b1;
        repeat (2) @(posedge I_SYS_CLK);
        I_FRONT_PANEL_IDENTIFY_BUTTON <= 1'b0;
        @(posedge I_SYS_CLK);
    endtask
    // Sends one request pulse; the two sources get opposite qualifiers.
    task automatic cmd(input logic [1:0] w, input logic on);
        {I_VENDOR_IDENTIFY_REQ, I_CHASSIS_IDENTIFY_REQ} <= w;
        {I_VENDOR_IDENTIFY_ON, I_CHASSIS_IDENTIFY_ON} <= {on, !on};
        @(posedge I_SYS_CLK);
        {I_VENDOR_IDENTIFY_REQ, I_CHASSIS_IDENTIFY_REQ} <= 2'h0;
        @(posedge I_SYS_CLK);
    endtask
endmodule
`default_nettype wire

//--- cilc_top_props.sv
// Port assertions for the identify indicator controller.
// Assumes binding to cilc_top with matching port names.
`timescale 1ns/10ps
`default_nettype none
module cilc_props (
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    input wire logic I_FRONT_PANEL_IDENTIFY_BUTTON,
    input wire logic I_CHASSIS_IDENTIFY_REQ,
    input wire logic I_CHASSIS_IDENTIFY_ON,
    input wire logic I_VENDOR_IDENTIFY_REQ,
    input wire logic I_VENDOR_IDENTIFY_ON,
    input wire logic O_IDENTIFY_INDICATOR_OUT_N,
    input wire logic O_IDENTIFY_ACTIVE
);
    logic bq, s, k;
    wire vr = I_VENDOR_IDENTIFY_REQ, cr = I_CHASSIS_IDENTIFY_REQ;
    wire pr = I_FRONT_PANEL_IDENTIFY_BUTTON & !bq & !vr & !cr, ev = pr | vr | cr;
    wire a = O_IDENTIFY_ACTIVE, n = O_IDENTIFY_INDICATOR_OUT_N;
    always_ff @(posedge I_SYS_CLK) bq <= !I_RST & I_FRONT_PANEL_IDENTIFY_BUTTON;
    always_ff @(posedge I_SYS_CLK) s <= !I_RST & !vr & !cr & (s ^ pr);
    always_ff @(posedge I_SYS_CLK)
    begin
        k <= I_RST ? 1'b0 : vr ? I_VENDOR_IDENTIFY_ON : cr ? I_CHASSIS_IDENTIFY_ON : k & !pr;
    end
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RST);
    property p_rst; disable iff (1'b0) I_RST |=> n && !a; endproperty
    a_rst: assert property (p_rst) else $error("not off after reset");
    property p_vnd; vr ##1 !ev |=> a == $past(I_VENDOR_IDENTIFY_ON, 2); endproperty
    a_vnd: assert property (p_vnd) else $error("vendor request ignored");
    property p_chs; cr && !vr ##1 !ev |=> a == $past(I_CHASSIS_IDENTIFY_ON, 2); endproperty
    a_chs: assert property (p_chs) else $error("chassis request ignored");
    property p_btn; pr ##1 !ev |=> a == !$past(s, 2) && n != a; endproperty
    a_btn: assert property (p_btn) else $error("press did not toggle");
    property p_hold; !ev [*3] |-> $stable(a); endproperty
    a_hold: assert property (p_hold) else $error("change without request");
    property p_dark; !a |-> n; endproperty
    a_dark: assert property (p_dark) else $error("lit while inactive");
    property p_track; !$past(I_RST) |-> a == $past(s | k); endproperty
    a_track: assert property (p_track) else $error("stale activation");
    property p_solid; $past(s & !I_RST) |-> !n; endproperty
    a_solid: assert property (p_solid) else $error("solid not lit");
    cover property (pr ##1 !ev ##1 a);
    cover property (vr && cr);
    cover property (k ##1 pr);
endmodule
bind cilc_top cilc_props i_cilc_props (.*);
`default_nettype wire

//--- cilc_tb_top.sv
// Self-checking bench for the identify indicator controller.
// Assumes cilc_peer drives every request input of the design.
`timescale 1ns/10ps
`default_nettype none
module cilc_tb_top;
    logic I_SYS_CLK = 1'b0, I_RST = 1'b1, s = 1'b0, k = 1'b0;
    wire I_FRONT_PANEL_IDENTIFY_BUTTON, I_CHASSIS_IDENTIFY_REQ, I_CHASSIS_IDENTIFY_ON;
    wire I_VENDOR_IDENTIFY_REQ, I_VENDOR_IDENTIFY_ON;
    logic O_IDENTIFY_INDICATOR_OUT_N, O_IDENTIFY_ACTIVE;
    int n_mismatch = 0, comparisons = 0, seed = 60, i;
    logic [31:0] r;
    always #4 I_SYS_CLK = !I_SYS_CLK;
    cilc_peer i_cilc_peer (.*);
    cilc_top i_cilc_top (.*);
    // Vendor wins over chassis; a press toggles solid and cancels blinking.
    function automatic logic [1:0] nxt(logic [1:0] sk, logic [1:0] w, logic on);
        return w[1] ? {1'b0, on} : w[0] ? {1'b0, !on} : {!sk[1], 1'b0};
    endfunction
    task automatic op(input logic [1:0] w, input logic on);
        if (w == 2'h0) i_cilc_peer.press();
        else i_cilc_peer.cmd(w, on);
        {s, k} = nxt({s, k}, w, on);
        chk();
        @(posedge I_SYS_CLK);
    endtask
    task automatic chk();
        @(negedge I_SYS_CLK);
        comparisons++;
        if ({O_IDENTIFY_ACTIVE, O_IDENTIFY_INDICATOR_OUT_N} !== {s | k, !(s | k)})
        begin
            n_mismatch++;
            $display("FAIL %0t got %h exp %h", $time,
                {O_IDENTIFY_ACTIVE, O_IDENTIFY_INDICATOR_OUT_N}, {s | k, !(s | k)});
        end
    endtask
    task automatic close_out();
        if (n_mismatch == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge I_SYS_CLK);
        I_RST <= 1'b0;
        @(posedge I_SYS_CLK);
        op(2'h0, 1'b0);
        op(2'h0, 1'b0);
        op(2'h2, 1'b1);
        op(2'h0, 1'b0);
        op(2'h1, 1'b0);
        op(2'h3, 1'b0);
        for (i = 0; i < 80; i++)
        begin
            r = $random(seed);
            op(r[1:0], r[2]);
        end
        I_RST <= 1'b1;
        repeat (2) @(posedge I_SYS_CLK);
        I_RST <= 1'b0;
        {s, k} = 2'h0;
        chk();
        @(posedge I_SYS_CLK);
        op(2'h0, 1'b0);
        close_out();
    end
endmodule
`default_nettype wire
